// >>> hdl/bcl_boot_loader.sv
// Purpose: boot probe of SPI flash and I2C EEPROM, speed strap, registers
// Assumes: pins are synchronised here; registers over AXI4-Lite
// Notes: Contract
// Contract
// - After reset, read four bytes at flash 0xFFFA and compare with 2DFU.
// - A good flash signature enables external code from address 0x0000.
// - A bad flash signature leaves code running from the internal ROM.
// - With no flash found, check EEPROM signatures at FCh and 17Ch.
// - A signed EEPROM supplies the configuration word that is loaded.
// - The strap level picks the slow (low) or fast (high) SPI rate; both dividers come to 1 cycle per phase, so the rate is the same.
// - In reset the strap pin is released with its pull-down on.
// - After reset the strap is latched, the pin drives data, pull-down off.
// - The latched rate reads back in the control register, reset 0x02.
// - Flash reads run in single-bit or dual-bit mode.
// - The SPI clock idles low for mode 0 and high for mode 3.
// - Without external memory the default configuration stays in use.
`timescale 1ns/100ps
module bcl_boot_loader #(
  parameter int AW = 16,
  parameter logic [31:0] CFG_DEFAULT = 32'h0000_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic spi_cs_n,
  output logic pin_clk_o,
  output logic pin_clk_oe,
  output logic pin_dq0_o,
  output logic pin_dq0_oe,
  output logic pin_dq0_pd_en,
  input wire logic pin_dq0_in,
  input wire logic spi_serial_in,
  output logic boot_done,
  output logic ext_exec_en,
  output logic rom_exec_en,
  output logic [15:0] exec_addr,
  output logic [31:0] cfg_word
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    bcl_pkg::bcl_state_t st;
    logic [1:0] wcnt;
    logic busy;
    logic [3:0] idx;
    logic [1:0] rd;
    logic nack;
    logic [31:0] sh;
    logic speed;
    logic dual;
    logic mode3;
    logic [1:0] src;
    logic [31:0] cfg;
    logic cs_n;
    logic pd;
    logic drv;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bcl_top_t;

  bcl_top_t q;
  bcl_top_t d;

  logic op_valid;
  logic op_ready;
  bcl_pkg::bcl_op_t op_code;
  logic [7:0] op_data;
  logic op_done;
  logic [7:0] rx_data;
  logic rx_nack;
  logic i2c_mode;
  logic [8:0] div;
  logic [3:0] hdr;
  logic [8:0] ofs;
  logic [31:0] rx_word;
  logic sh_clk_o;
  logic sh_clk_oe;
  logic sh_d0_o;
  logic sh_d0_oe;

  // Serial engine shared by the SPI and I2C phases
  bcl_shifter u_shifter (
    .aclk(aclk),
    .aresetn(aresetn),
    .i2c_mode(i2c_mode),
    .cpol(q.mode3),
    .div(div),
    .op_valid(op_valid),
    .op_ready(op_ready),
    .op_code(op_code),
    .op_data(op_data),
    .op_done(op_done),
    .rx_data(rx_data),
    .rx_nack(rx_nack),
    .d0_in(q.s2[1]),
    .d1_in(q.s2[0]),
    .clk_o(sh_clk_o),
    .clk_oe(sh_clk_oe),
    .d0_o(sh_d0_o),
    .d0_oe(sh_d0_oe)
  );

  // Bit rate for the active phase
  always_comb begin
    i2c_mode = (q.st == bcl_pkg::ST_I2C);
    if (i2c_mode) begin
      div = 9'(bcl_pkg::I2C_DIV);
    end else if (q.speed) begin
      div = 9'(bcl_pkg::SPI_FAST_DIV);
    end else begin
      div = 9'(bcl_pkg::SPI_SLOW_DIV);
    end
  end

  // Next operation for the probe sequence
  always_comb begin
    hdr = q.dual ? 4'h5 : 4'h4;
    rx_word = {q.sh[23:0], rx_data};
    op_valid = ~q.busy & op_ready &
               ((q.st == bcl_pkg::ST_SPI) | (q.st == bcl_pkg::ST_I2C));
    op_code = bcl_pkg::OP_SPI;
    op_data = 8'h00;
    if (q.rd == 2'h0) begin
      ofs = bcl_pkg::EE_SIG1_OFS;
    end else if (q.rd == 2'h1) begin
      ofs = bcl_pkg::EE_SIG2_OFS;
    end else begin
      ofs = bcl_pkg::EE_CFG_OFS;
    end
    if (q.st == bcl_pkg::ST_SPI) begin
      // Read command, address, optional dummy, four bytes
      case (q.idx)
        4'h0: op_data = q.dual ? bcl_pkg::CMD_DREAD : bcl_pkg::CMD_READ;
        4'h1: op_data = bcl_pkg::FLASH_SIG_ADDR[23:16];
        4'h2: op_data = bcl_pkg::FLASH_SIG_ADDR[15:8];
        4'h3: op_data = bcl_pkg::FLASH_SIG_ADDR[7:0];
        default: op_data = 8'h00;
      endcase
      if (q.idx >= hdr && q.dual) begin
        op_code = bcl_pkg::OP_DUAL;
      end
    end else begin
      // Random read of four EEPROM bytes
      case (q.idx)
        4'h0, 4'h3: op_code = bcl_pkg::OP_START;
        4'h1: begin
          op_code = bcl_pkg::OP_WR;
          op_data = {bcl_pkg::EE_DEV[6:1], ofs[8], 1'b0};
        end
        4'h2: begin
          op_code = bcl_pkg::OP_WR;
          op_data = ofs[7:0];
        end
        4'h4: begin
          op_code = bcl_pkg::OP_WR;
          op_data = {bcl_pkg::EE_DEV[6:1], ofs[8], 1'b1};
        end
        4'h9: op_code = bcl_pkg::OP_STOP;
        default: begin
          op_code = bcl_pkg::OP_RD;
          op_data = {7'h00, q.idx == 4'h8};
        end
      endcase
    end
  end

  // Sequencer, strap latch and register slave
  always_comb begin
    d = q;
    d.s1 = {pin_dq0_in, spi_serial_in};
    d.s2 = q.s1;
    s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
    s_axi_wready = s_axi_awready;
    s_axi_arready = ~q.rvalid;

    // Strap sampled once the synchroniser has filled
    if (q.st == bcl_pkg::ST_STRAP) begin
      d.wcnt = q.wcnt + 2'h1;
      if (q.wcnt == bcl_pkg::STRAP_WAIT) begin
        d.speed = q.s2[1];
        d.st = bcl_pkg::ST_SPI;
        d.idx = 4'h0;
      end
    end

    if (op_valid) begin
      d.busy = 1'b1;
    end

    // Results of each finished serial operation
    if (op_done && q.busy) begin
      d.busy = 1'b0;
      d.idx = q.idx + 4'h1;
      if (q.st == bcl_pkg::ST_SPI) begin
        if (q.idx >= hdr) begin
          d.sh = rx_word;
        end
        if (q.idx == hdr + 4'h3) begin
          if (rx_word == bcl_pkg::SIG_DFU) begin
            d.st = bcl_pkg::ST_DONE;
            d.src = bcl_pkg::SRC_SPI;
          end else begin
            d.st = bcl_pkg::ST_I2C;
            d.idx = 4'h0;
            d.rd = 2'h0;
            d.nack = 1'b0;
          end
        end
      end else begin
        if (q.idx >= 4'h5 && q.idx <= 4'h8) begin
          d.sh = rx_word;
        end
        if ((q.idx == 4'h1 || q.idx == 4'h2 || q.idx == 4'h4) &&
            rx_nack) begin
          d.nack = 1'b1;
          d.idx = 4'h9;
        end
        if (q.idx == 4'h9) begin
          d.idx = 4'h0;
          d.rd = q.rd + 2'h1;
          if (q.nack ||
              (q.rd == 2'h0 && q.sh != bcl_pkg::SIG_EE1) ||
              (q.rd == 2'h1 && q.sh != bcl_pkg::SIG_EE2)) begin
            d.st = bcl_pkg::ST_DONE;
            d.src = bcl_pkg::SRC_ROM;
            d.cfg = CFG_DEFAULT;
          end else if (q.rd == 2'h2) begin
            d.st = bcl_pkg::ST_DONE;
            d.src = bcl_pkg::SRC_EE;
            d.cfg = q.sh;
          end
        end
      end
    end

    // Write channel
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_awready) begin
      d.bvalid = 1'b1;
      d.bresp = bcl_pkg::RESP_OKAY;
      if (s_axi_awaddr == AW'(bcl_pkg::ADDR_CTRL)) begin
        if (s_axi_wstrb[0] && q.st != bcl_pkg::ST_SPI) begin
          d.dual = s_axi_wdata[bcl_pkg::CTRL_DUAL];
          d.mode3 = s_axi_wdata[bcl_pkg::CTRL_MODE3];
          if (s_axi_wdata[bcl_pkg::CTRL_PROBE] &&
              q.st == bcl_pkg::ST_DONE) begin
            d.st = bcl_pkg::ST_SPI;
            d.idx = 4'h0;
            d.src = bcl_pkg::SRC_ROM;
          end
        end
      end else if (s_axi_awaddr == AW'(bcl_pkg::ADDR_STAT)) begin
        d.bresp = bcl_pkg::RESP_OKAY;
      end else if (s_axi_awaddr == AW'(bcl_pkg::ADDR_CFG)) begin
        d.bresp = bcl_pkg::RESP_OKAY;
      end else begin
        d.bresp = bcl_pkg::RESP_SLVERR;
      end
    end

    // Read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = bcl_pkg::RESP_OKAY;
      d.rdata = 32'h0000_0000;
      if (s_axi_araddr == AW'(bcl_pkg::ADDR_CTRL)) begin
        d.rdata[bcl_pkg::CTRL_DUAL] = q.dual;
        d.rdata[bcl_pkg::CTRL_SPEED] = q.speed;
        d.rdata[bcl_pkg::CTRL_MODE3] = q.mode3;
      end else if (s_axi_araddr == AW'(bcl_pkg::ADDR_STAT)) begin
        d.rdata[bcl_pkg::STAT_SRC +: 2] = q.src;
        d.rdata[bcl_pkg::STAT_DONE] = (q.st == bcl_pkg::ST_DONE);
        d.rdata[bcl_pkg::STAT_BUSY] = (q.st == bcl_pkg::ST_SPI) |
                                      (q.st == bcl_pkg::ST_I2C);
      end else if (s_axi_araddr == AW'(bcl_pkg::ADDR_CFG)) begin
        d.rdata = q.cfg;
      end else begin
        d.rresp = bcl_pkg::RESP_SLVERR;
      end
    end

    // Pin control follows the next state
    d.cs_n = (d.st != bcl_pkg::ST_SPI);
    d.pd = (d.st == bcl_pkg::ST_STRAP);
    d.drv = (d.st != bcl_pkg::ST_STRAP);
  end

  // State register; strap pin released with pull-down in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= bcl_pkg::ST_STRAP;
      q.speed <= bcl_pkg::CTRL_RST[bcl_pkg::CTRL_SPEED];
      q.cfg <= CFG_DEFAULT;
      q.cs_n <= 1'b1;
      q.pd <= 1'b1;
      q.drv <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign spi_cs_n = q.cs_n;
  assign pin_clk_o = sh_clk_o;
  assign pin_clk_oe = sh_clk_oe;
  assign pin_dq0_o = sh_d0_o;
  assign pin_dq0_oe = sh_d0_oe & q.drv;
  assign pin_dq0_pd_en = q.pd;
  assign boot_done = (q.st == bcl_pkg::ST_DONE);
  assign ext_exec_en = (q.src == bcl_pkg::SRC_SPI);
  assign rom_exec_en = (q.src != bcl_pkg::SRC_SPI);
  assign exec_addr = bcl_pkg::EXEC_ADDR;
  assign cfg_word = q.cfg;

endmodule

// >>> hdl/bcl_pkg.sv
// Purpose: shared constants and types of the boot configuration loader
// Assumes: 100 MHz system clock, four clock phases per serial bit
// Notes: signature words carry the first byte read in their top byte
package bcl_pkg;

  // Clock rates in kHz
  localparam int CLK_KHZ = 100000;
  localparam int SPI_SLOW_KHZ = 30000;
  localparam int SPI_FAST_KHZ = 60000;
  localparam int I2C_KHZ = 100;

  // Cycles per bit phase; a least time rounds up
  localparam int SPI_SLOW_DIV =
    (CLK_KHZ + 4 * SPI_SLOW_KHZ - 1) / (4 * SPI_SLOW_KHZ);
  localparam int SPI_FAST_DIV =
    (CLK_KHZ + 4 * SPI_FAST_KHZ - 1) / (4 * SPI_FAST_KHZ);
  localparam int I2C_DIV = (CLK_KHZ + 4 * I2C_KHZ - 1) / (4 * I2C_KHZ);
  localparam int DIV_W = 9;

  // Strap settles through the two-stage synchroniser
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // Register map, byte addresses
  localparam logic [15:0] ADDR_CTRL = 16'h2400;
  localparam logic [15:0] ADDR_STAT = 16'h2404;
  localparam logic [15:0] ADDR_CFG = 16'h2408;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_SPEED = 1;
  localparam int CTRL_MODE3 = 2;
  localparam int CTRL_PROBE = 7;
  localparam int STAT_SRC = 0;
  localparam int STAT_DONE = 2;
  localparam int STAT_BUSY = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Boot sources
  localparam logic [1:0] SRC_ROM = 2'h0;
  localparam logic [1:0] SRC_SPI = 2'h1;
  localparam logic [1:0] SRC_EE = 2'h2;

  // Signatures and locations
  localparam logic [31:0] SIG_DFU = 32'h3244_4655;
  localparam logic [31:0] SIG_EE1 = 32'h4154_4132;
  localparam logic [31:0] SIG_EE2 = 32'h6563_6631;
  localparam logic [23:0] FLASH_SIG_ADDR = 24'h00_FFFA;
  localparam logic [15:0] EXEC_ADDR = 16'h0000;
  localparam logic [8:0] EE_SIG1_OFS = 9'h0FC;
  localparam logic [8:0] EE_SIG2_OFS = 9'h17C;
  localparam logic [8:0] EE_CFG_OFS = 9'h000;
  localparam logic [6:0] EE_DEV = 7'h50;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_DREAD = 8'h3B;

  // Shifter operations
  typedef enum logic [2:0] {
    OP_SPI, OP_DUAL, OP_START, OP_STOP, OP_WR, OP_RD
  } bcl_op_t;

  // Boot sequencer states
  typedef enum logic [3:0] {
    ST_STRAP = 4'b0001,
    ST_SPI = 4'b0010,
    ST_I2C = 4'b0100,
    ST_DONE = 4'b1000
  } bcl_state_t;

endpackage

// >>> hdl/bcl_shifter.sv
// Purpose: serial byte engine for SPI (single, dual) and I2C
// Assumes: d0_in and d1_in are already synchronised
// Notes: four phases per bit, data set in phase 0, sampled in phase 3
`timescale 1ns/100ps
module bcl_shifter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic i2c_mode,
  input wire logic cpol,
  input wire logic [8:0] div,
  input wire logic op_valid,
  output logic op_ready,
  input wire bcl_pkg::bcl_op_t op_code,
  input wire logic [7:0] op_data,
  output logic op_done,
  output logic [7:0] rx_data,
  output logic rx_nack,
  input wire logic d0_in,
  input wire logic d1_in,
  output logic clk_o,
  output logic clk_oe,
  output logic d0_o,
  output logic d0_oe
);

  typedef struct packed {
    logic busy;
    bcl_pkg::bcl_op_t op;
    logic [1:0] ph;
    logic [3:0] slot;
    logic [7:0] sh;
    logic nack;
    logic ack;
    logic done;
    logic [8:0] cnt;
    logic [3:0] pins;
  } bcl_shf_t;

  bcl_shf_t q;
  bcl_shf_t d;
  logic [3:0] last;

  // Pin levels {clk_o, clk_oe, d0_o, d0_oe} for one phase
  function automatic logic [3:0] pins_f(
    input bcl_pkg::bcl_op_t op,
    input logic [1:0] ph,
    input logic [3:0] slot,
    input logic b7,
    input logic nack,
    input logic i2c,
    input logic pol,
    input logic busy
  );
    logic scl;
    logic sda;
    scl = ph[1];
    sda = 1'b1;
    if (!busy) begin
      return i2c ? 4'b0000 : {pol, 1'b1, 1'b0, 1'b1};
    end
    case (op)
      bcl_pkg::OP_SPI: return {ph[1], 1'b1, b7, 1'b1};
      bcl_pkg::OP_DUAL: return {ph[1], 1'b1, 1'b0, 1'b0};
      bcl_pkg::OP_START: begin
        scl = ph[0] ^ ph[1];
        sda = ~ph[1];
      end
      bcl_pkg::OP_STOP: begin
        scl = |ph;
        sda = &ph;
      end
      bcl_pkg::OP_WR: sda = (slot == 4'h8) ? 1'b1 : b7;
      default: sda = (slot == 4'h8) ? nack : 1'b1;
    endcase
    return {1'b0, ~scl, 1'b0, ~sda};
  endfunction

  // Bit slot sequencing and sampling
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.op)
      bcl_pkg::OP_SPI: last = 4'h7;
      bcl_pkg::OP_DUAL: last = 4'h3;
      bcl_pkg::OP_WR, bcl_pkg::OP_RD: last = 4'h8;
      default: last = 4'h0;
    endcase
    if (!q.busy) begin
      if (op_valid) begin
        d.busy = 1'b1;
        d.op = op_code;
        d.sh = op_data;
        d.nack = op_data[0];
        d.ph = 2'h0;
        d.slot = 4'h0;
        d.cnt = div - 9'h1;
      end
    end else if (q.cnt != 9'h0) begin
      d.cnt = q.cnt - 9'h1;
    end else begin
      d.cnt = div - 9'h1;
      d.ph = q.ph + 2'h1;
      if (q.ph == 2'h3) begin
        case (q.op)
          bcl_pkg::OP_SPI: d.sh = {q.sh[6:0], d1_in};
          bcl_pkg::OP_DUAL: d.sh = {q.sh[5:0], d1_in, d0_in};
          bcl_pkg::OP_WR, bcl_pkg::OP_RD: begin
            if (q.slot == 4'h8) begin
              d.ack = d0_in;
            end else begin
              d.sh = {q.sh[6:0], d0_in};
            end
          end
          default: d.ack = 1'b0;
        endcase
        d.slot = q.slot + 4'h1;
        if (q.slot == last) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
    end
    d.pins = pins_f(d.op, d.ph, d.slot, d.sh[7], d.nack, i2c_mode, cpol,
                    d.busy);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign op_ready = ~q.busy;
  assign op_done = q.done;
  assign rx_data = q.sh;
  assign rx_nack = q.ack;
  assign {clk_o, clk_oe, d0_o, d0_oe} = q.pins;

endmodule

// >>> sim/bcl_boot_loader_assertions.sv
// Purpose: port checks of the boot loader
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every boot loader instance
`timescale 1ns/100ps
module bcl_boot_loader_assertions #(
  parameter int AW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic spi_cs_n,
  input wire logic pin_clk_oe,
  input wire logic pin_dq0_oe,
  input wire logic pin_dq0_pd_en,
  input wire logic boot_done,
  input wire logic ext_exec_en,
  input wire logic rom_exec_en,
  input wire logic [15:0] exec_addr
);
  logic rd_map;
  // All checks on the system clock, muted in reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Read address hits one of the three registers
  assign rd_map = (s_axi_araddr == AW'(16'h2400)) ||
    (s_axi_araddr == AW'(16'h2404)) || (s_axi_araddr == AW'(16'h2408));
  a_strap_phase: assert property (
    $rose(aresetn) |-> (pin_dq0_pd_en && !pin_dq0_oe) [*2]
    ##[1:2] !pin_dq0_pd_en) else $error("strap phase wrong");
  a_pd_off_drive: assert property (
    pin_dq0_oe |-> !pin_dq0_pd_en) else $error("pull-down while driving");
  a_probe_start: assert property (
    $rose(aresetn) |-> spi_cs_n [*2] ##[1:6] !spi_cs_n)
    else $error("flash probe not started");
  a_cs_probe_only: assert property (
    !spi_cs_n |-> !boot_done && pin_clk_oe) else $error("select outside probe");
  a_exec_source: assert property (
    ext_exec_en |-> boot_done && exec_addr == 16'h0000)
    else $error("external start wrong");
  a_rom_excl: assert property (
    !boot_done |-> rom_exec_en && !ext_exec_en)
    else $error("code source unclear");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write not answered");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_rd: assert property (
    s_axi_arvalid && s_axi_arready && !rd_map |=>
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read accepted");
endmodule

bind bcl_boot_loader bcl_boot_loader_assertions #(.AW(AW)) u_bcl_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .spi_cs_n, .pin_clk_oe, .pin_dq0_oe, .pin_dq0_pd_en,
  .boot_done, .ext_exec_en, .rom_exec_en, .exec_addr
);

// >>> sim/bcl_flash_model.sv
// Purpose: behavioural serial flash for the boot probe
// Assumes: input on rising clock edges, so modes 0 and 3 both work
// Notes: only the signature word at its fixed address is stored
`timescale 1ns/100ps
module bcl_flash_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic programmed,
  output logic miso,
  output logic io0,
  output logic io0_oe
);
  logic [31:0] hdr;
  logic [31:0] word;
  int rc;
  // Stored word: the upgrade signature, or erased cells
  assign word = programmed ? 32'h3244_4655 : 32'hFFFF_FFFF;
  // Lines released at time zero
  initial begin
    miso = 1'b0;
    io0 = 1'b0;
    io0_oe = 1'b0;
    rc = 0;
  end
  // Each select starts a new frame
  always @(negedge cs_n) begin
    rc = 0;
  end
  // Command and address shift in on the rising edge
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (rc < 32) begin
        hdr = {hdr[30:0], mosi};
      end
      rc = rc + 1;
    end
  end
  // Data leaves on falling edges; released lines fall to the pull-down
  always @(negedge sclk or posedge cs_n) begin
    miso <= 1'b0;
    io0_oe <= 1'b0;
    if (!cs_n && hdr == 32'h0300_FFFA && rc >= 32 && rc < 64) begin
      miso <= word[63 - rc];
    end
    if (!cs_n && hdr == 32'h3B00_FFFA && rc >= 40 && rc < 56) begin
      miso <= word[31 - 2 * (rc - 40)];
      io0 <= word[30 - 2 * (rc - 40)];
      io0_oe <= 1'b1;
    end
  end
endmodule

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the boot loader
// Assumes: flash model on the SPI pins, strap resistor on the data pin
// Notes: no EEPROM fitted, so the I2C probe ends on its first address
`timescale 1ns/100ps
`define CHK(a, e, m) \
  begin \
    n_tests++; \
    if ((a) !== (e)) begin \
      num_errors++; \
      $display("MISMATCH t=%0t %s", $time, m); \
    end \
  end
module tb_top;
  localparam int AW = 16;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, spi_cs_n;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, cfg_word, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic pin_clk_o, pin_clk_oe, pin_dq0_o, pin_dq0_oe, pin_dq0_pd_en;
  logic pin_dq0_in, spi_serial_in, boot_done, ext_exec_en, rom_exec_en;
  logic [15:0] exec_addr;
  logic strap, programmed, fl_io0, fl_io0_oe, sclk_line, dq_q;
  int num_errors, n_tests, cycles, starts, n;
  bcl_boot_loader #(.AW(AW)) u_bcl_boot_loader (.*);
  bcl_flash_model u_bcl_flash_model (.sclk(sclk_line), .cs_n(spi_cs_n),
    .mosi(pin_dq0_in), .programmed(programmed), .miso(spi_serial_in),
    .io0(fl_io0), .io0_oe(fl_io0_oe));
  // Pin levels: device first, then flash, then board pulls
  assign sclk_line = pin_clk_oe ? pin_clk_o : 1'b1;
  assign pin_dq0_in = pin_dq0_oe ? pin_dq0_o : fl_io0_oe ? fl_io0 : strap;
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard and I2C start counter
  always @(posedge aclk) begin
    cycles++;
    dq_q <= pin_dq0_in;
    if (spi_cs_n && sclk_line && dq_q && !pin_dq0_in) begin
      starts++;
    end
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic reset_run(input int c, input logic s, input logic p);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap <= s;
    programmed <= p;
    repeat (c) @(posedge aclk);
    `CHK(pin_dq0_pd_en, 1'b1, "pull-down in reset")
    `CHK(pin_dq0_oe, 1'b0, "strap pin driven")
    `CHK(spi_cs_n, 1'b1, "select in reset")
    aresetn <= 1'b1;
  endtask
  task automatic axi_wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic hs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      hs = s_axi_awready;
      @(posedge aclk);
    end while (hs !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // Ready comes one edge late, so the slave must hold its answer
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
    end while (hs !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [AW-1:0] a);
    logic hs;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      hs = s_axi_arready;
      @(posedge aclk);
    end while (hs !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // Ready comes one edge late, so the read data must stand
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
    end while (hs !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_done();
    do begin
      @(posedge aclk);
    end while (boot_done !== 1'b1);
  endtask
  // Main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    strap = 1'b0;
    programmed = 1'b1;
    // Signed flash, slow strap, single bit, mode 0
    reset_run(5, 1'b0, 1'b1);
    wait_done();
    `CHK(ext_exec_en, 1'b1, "flash boot")
    `CHK(exec_addr, 16'h0000, "start address")
    `CHK(pin_clk_o, 1'b0, "mode 0 idle")
    axi_rd(16'h2400);
    `CHK(rd[7:0], 8'h00, "slow rate")
    axi_rd(16'h2404);
    `CHK(rd[3:0], 4'h5, "flash source")
    axi_rd(16'h2410);
    `CHK({rs, rd}, {2'h2, 32'h0000_0000}, "unmapped read")
    axi_wr(16'h2500, 32'h0000_0001);
    `CHK(rs, 2'h2, "unmapped write")
    // Re-probe dual bit in mode 3; the rate bit is read-only
    axi_wr(16'h2400, 32'h0000_0087);
    `CHK(rs, 2'h0, "control write")
    axi_rd(16'h2404);
    `CHK(rd[3:2], 2'h2, "probing")
    wait_done();
    `CHK(ext_exec_en, 1'b1, "dual boot")
    `CHK(pin_clk_o, 1'b1, "mode 3 idle")
    axi_rd(16'h2400);
    `CHK(rd[7:0], 8'h05, "control readback")
    // Erased flash, fast strap, empty I2C bus
    reset_run(100, 1'b1, 1'b0);
    n = starts;
    repeat (6) @(posedge aclk);
    axi_rd(16'h2400);
    `CHK(rd[7:0], 8'h02, "fast rate")
    wait_done();
    `CHK(starts > n, 1'b1, "eeprom probe")
    `CHK(rom_exec_en, 1'b1, "rom boot")
    `CHK(cfg_word, 32'h0000_0000, "default config")
    axi_rd(16'h2404);
    `CHK(rd[3:0], 4'h4, "rom source")
    axi_rd(16'h2408);
    `CHK({rs, rd}, {2'h0, 32'h0000_0000}, "config register")
    // Byte lane 0 off: the control write must leave the register alone
    s_axi_wstrb <= 4'hE;
    axi_wr(16'h2400, 32'h0000_0005);
    `CHK(rs, 2'h0, "masked write answer")
    axi_rd(16'h2400);
    `CHK(rd[7:0], 8'h02, "masked write")
    test_done();
  end
endmodule
